// ==== common/hpp_cfg.svh ====
// Constants for the host parallel byte port: control fields, reset values and status layout.
// What this block does
// - One 16-bit input buffer, one 16-bit output buffer.
// - Drive input-full and output-empty flag pins.
// - Status byte only with status select, proper byte select.
// - Strobes count only while chip select is low.
// - Strobe assertion raises enabled core interrupt.
// - Control bit 0 picks 8 or 16 bit.
// - Control bit 3 sets byte select polarity.
// - 16-bit byte mapping swaps with polarity bit.
// - 8-bit mode moves low byte only.
// - 16-bit flags set after high or low byte.
// - 8-bit flags set on every completed legal data access.
// - Control bit 1 picks separate or single strobe.
// - Separate strobes active low; bit 2 single polarity.
// - Control bit 4 sets flag pin polarity; the full pin in OR mode stays positive.
// - Control bit 5 puts flag OR on full pin.
// - Control bit 7 inverts status empty bit only.
// - Status byte: full bit 3, empty bit 2.
`ifndef HPP_CFG_SVH
`define HPP_CFG_SVH

// Field positions inside the control register.
`define HPP_CTL_WIDTH_BIT 0
`define HPP_CTL_STROBE_BIT 1
`define HPP_CTL_DS_POL_BIT 2
`define HPP_CTL_BSEL_POL_BIT 3
`define HPP_CTL_FLAG_POL_BIT 4
`define HPP_CTL_FLAG_OR_BIT 5
`define HPP_CTL_STAT_EMPTY_POL_BIT 7

// Field positions inside the status byte.
`define HPP_STAT_FULL_BIT 3
`define HPP_STAT_EMPTY_BIT 2

// Reset values.
`define HPP_CTL_RESET 8'h00
`define HPP_BUF_RESET 16'h0000
`define HPP_BYTE_ZERO 8'h00
// Status byte after reset: nothing received and the output buffer empty.
`define HPP_STAT_RESET 8'h04

// Number of synchroniser stages on every host pin.
`define HPP_SYNC_STAGES 2

`endif

// ==== common/hpp_pkg.sv ====
// Types shared by the host parallel byte port modules.
package hpp_pkg;

	// Host pins after synchronisation, in one bundle.
	typedef struct packed {
		logic chip_select_n;
		logic input_data_strobe;
		logic output_data_strobe;
		logic byte_select;
		logic status_select;
		logic [7:0] host_data_bus;
	} hpp_pins_t;

	// Whole state of the port.
	typedef struct packed {
		logic [7:0] host_port_control;
		logic [15:0] in_buf;
		logic [15:0] out_buf;
		logic input_full_flag;
		logic output_empty_flag;
		logic wr_act;
		logic wr_valid;
		logic wr_high;
		logic wr_last;
		logic [7:0] wr_byte;
		logic rd_act;
		logic rd_valid;
		logic rd_last;
		logic [7:0] bus_out;
		logic bus_oe_n;
		logic irq_in;
		logic irq_out;
		logic pin_full;
		logic pin_empty;
		logic [7:0] host_port_status_byte;
	} hpp_state_t;

endpackage

// ==== dv/hpp_host.sv ====
// Host model that drives the pins of the parallel byte port.
`timescale 1ns/10ps
module hpp_host (
	input wire logic clk,
	input wire logic single,
	input wire logic ds_pol,
	input wire logic [7:0] dev_bus,
	output logic cs_n,
	output logic ids,
	output logic ods,
	output logic bsel,
	output logic ssel,
	output logic [7:0] bus
);
	// Strobes rest inactive; a single strobe rests at the inverse of its active level.
	task automatic idle();
		ids = single ? ~ds_pol : 1'b1;
		ods = 1'b1;
	endtask
	// All pins start idle so the first edges see no access.
	initial begin
		cs_n = 1'b1;
		ids = 1'b1;
		ods = 1'b1;
		bsel = 1'b0;
		ssel = 1'b0;
		bus = 8'h00;
	end
	// One byte access; with en low the chip select stays high and the strobe must be ignored.
	task automatic acc(input logic en, rd, bs, ss, input logic [7:0] d, output logic [7:0] q);
		@(negedge clk);
		cs_n = ~en;
		bsel = bs;
		ssel = ss;
		bus = d;
		ods = single ? rd : 1'b1;
		@(negedge clk);
		if (single) begin
			ids = ds_pol;
		end else if (rd) begin
			ods = 1'b0;
		end else begin
			ids = 1'b0;
		end
		// Strobe stands four cycles, longer than the sync path plus the register.
		repeat (4) @(negedge clk);
		q = dev_bus;
		idle();
		repeat (4) @(negedge clk);
		cs_n = 1'b1;
		bus = ~d;
	endtask
endmodule

// ==== dv/hpp_port_chk.sv ====
// Port-level assertions for the host parallel byte port.
`timescale 1ns/10ps
module hpp_port_chk (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic port_chip_select_n,
	input wire logic host_data_bus_oe_n,
	input wire logic input_full_flag,
	input wire logic output_empty_flag,
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	input wire logic [7:0] ctrl_rdata,
	input wire logic [7:0] status_rdata,
	input wire logic core_in_rd,
	input wire logic core_out_wr,
	input wire logic irq_in_strobe,
	input wire logic irq_out_strobe
);
	// Counts edges with chip select high, so the sync path is known to be empty.
	// Three edges cover the two sync stages and the access register behind them.
	logic [2:0] quiet_ff;
	logic [2:0] nxt_quiet;
	logic quiet;
	assign quiet = quiet_ff >= 3'h3;
	always_comb begin
		nxt_quiet = quiet_ff;
		if (sys_rst || !port_chip_select_n) begin
			nxt_quiet = 3'h0;
		end else if (quiet_ff != 3'h7) begin
			nxt_quiet = quiet_ff + 3'h1;
		end
	end
	always_ff @(posedge clk) begin
		quiet_ff <= nxt_quiet;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence s_quiet_run;
		quiet [*2];
	endsequence
	property p_reset;
		disable iff (1'b0) sys_rst |=> ctrl_rdata == 8'h00 && status_rdata == 8'h04 &&
			!input_full_flag && output_empty_flag && host_data_bus_oe_n;
	endproperty
	property p_ctrl;
		ctrl_wr |=> ctrl_rdata == $past(ctrl_wdata);
	endproperty
	property p_in_clr;
		core_in_rd && quiet |=> !status_rdata[3];
	endproperty
	property p_out_clr;
		core_out_wr && quiet && !ctrl_wr |=> status_rdata[2] == ctrl_rdata[7];
	endproperty
	property p_pin_empty;
		!ctrl_wr && !$past(ctrl_wr) && !$past(ctrl_wr, 2) |->
			output_empty_flag == (status_rdata[2] ^ ctrl_rdata[4] ^ ctrl_rdata[7]);
	endproperty
	property p_pin_full;
		!ctrl_wr && !$past(ctrl_wr) && !$past(ctrl_wr, 2) |->
			input_full_flag == (ctrl_rdata[5] ? status_rdata[3] | status_rdata[2] ^ ctrl_rdata[7] :
			status_rdata[3] ^ ctrl_rdata[4]);
	endproperty
	property p_stat_rsvd;
		status_rdata[7:4] == 4'h0 && status_rdata[1:0] == 2'h0;
	endproperty
	property p_irq_cs;
		irq_in_strobe || irq_out_strobe |-> !$past(port_chip_select_n, 3);
	endproperty
	property p_irq_pulse;
		$rose(irq_out_strobe) |=> $fell(irq_out_strobe);
	endproperty
	property p_quiet;
		s_quiet_run |-> host_data_bus_oe_n && !irq_in_strobe && !irq_out_strobe;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");
	a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
	a_in_clr: assert property (p_in_clr) else $error("full not cleared");
	a_out_clr: assert property (p_out_clr) else $error("empty not cleared");
	a_pin_empty: assert property (p_pin_empty) else $error("empty pin wrong");
	a_pin_full: assert property (p_pin_full) else $error("full pin wrong");
	a_stat_rsvd: assert property (p_stat_rsvd) else $error("status spare bits set");
	a_irq_cs: assert property (p_irq_cs) else $error("irq without select");
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
	a_quiet: assert property (p_quiet) else $error("activity while deselected");
endmodule
bind hpp_port hpp_port_chk i_chk (.clk, .sys_rst, .port_chip_select_n, .host_data_bus_oe_n,
	.input_full_flag, .output_empty_flag, .ctrl_wr, .ctrl_wdata, .ctrl_rdata, .status_rdata,
	.core_in_rd, .core_out_wr, .irq_in_strobe, .irq_out_strobe);

// ==== dv/tb.sv ====
// Self-checking bench for the host parallel byte port.
`timescale 1ns/10ps
module tb;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ctrl_wr = 1'b0, core_in_rd = 1'b0, core_out_wr = 1'b0;
	logic int_en_in = 1'b0, int_en_out = 1'b0;
	logic [7:0] ctrl_wdata = 8'h00, cfg = 8'h00, q, hbus, dbus, wbus, ctrl_rd, stat_rd;
	logic [15:0] core_out_data = 16'h0000, core_in, w;
	logic cs_n, ids, ods, bsel, ssel, oe_n, pin_f, pin_e, irq_i, irq_o;
	logic full, empty;
	int failures = 0, samples_checked = 0, n_i = 0, n_o = 0, e_i, e_o;
	always #12.5 clk = ~clk;
	// Wire level of the shared bus: the device wins while it drives.
	assign wbus = oe_n ? hbus : dbus;
	always @(posedge clk) begin
		n_i += irq_i;
		n_o += irq_o;
	end
	hpp_host i_host (.clk(clk), .single(cfg[1]), .ds_pol(cfg[2]), .dev_bus(wbus), .cs_n(cs_n),
		.ids(ids), .ods(ods), .bsel(bsel), .ssel(ssel), .bus(hbus));
	hpp_port i_dut (.clk(clk), .sys_rst(sys_rst), .port_chip_select_n(cs_n),
		.input_data_strobe(ids), .output_data_strobe(ods), .byte_select(bsel),
		.status_select(ssel), .host_data_bus_in(wbus), .host_data_bus_out(dbus),
		.host_data_bus_oe_n(oe_n), .input_full_flag(pin_f), .output_empty_flag(pin_e),
		.ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rd), .status_rdata(stat_rd),
		.core_in_rd(core_in_rd), .core_in_data(core_in), .core_out_wr(core_out_wr),
		.core_out_data(core_out_data), .int_en_in(int_en_in), .int_en_out(int_en_out),
		.irq_in_strobe(irq_i), .irq_out_strobe(irq_o));
	task automatic chk(input string nm, input logic [15:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Status byte that the model expects from its own flags and the control value.
	function automatic logic [7:0] stat_exp();
		return {4'h0, full, empty ^ cfg[7], 2'b00};
	endfunction
	// Status byte and flag pins as the model predicts them.
	task automatic flags();
		repeat (2) @(negedge clk);
		chk("status", stat_rd, stat_exp());
		chk("empty_pin", pin_e, empty ^ cfg[4]);
		chk("full_pin", pin_f, cfg[5] ? full | empty : full ^ cfg[4]);
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		@(negedge clk);
	endtask
	task automatic stop_test();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Watchdog set well beyond the twelve rounds of traffic.
	initial begin
		#400000;
		failures++;
		stop_test();
	end
	initial begin
		void'($urandom(49));
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge clk);
		full = 1'b0;
		empty = 1'b1;
		flags();
		for (int it = 0; it < 12; it++) begin
			cfg = 8'($urandom) & 8'hbf;
			int_en_in = 1'($urandom);
			int_en_out = 1'($urandom);
			ctrl_wdata = cfg;
			pulse(ctrl_wr);
			chk("ctrl", ctrl_rd, cfg);
			i_host.idle();
			repeat (4) @(negedge clk);
			n_i = 0;
			n_o = 0;
			e_i = 0;
			e_o = 0;
			// A strobe with chip select high must leave everything alone.
			i_host.acc(1'b0, 1'b0, cfg[0] | cfg[3], 1'b0, 8'h5a, q);
			flags();
			w = 16'($urandom);
			for (int b = 0; b < 2; b++) begin
				if (!cfg[0] && b != cfg[3]) continue;
				i_host.acc(1'b1, 1'b0, b[0], 1'b0, (b[0] ^ cfg[3]) ? w[15:8] : w[7:0], q);
				e_i += int_en_in;
				if (!cfg[0] || b == 1) full = 1'b1;
				flags();
			end
			chk("in_buf", core_in & {{8{cfg[0]}}, 8'hff}, w & {{8{cfg[0]}}, 8'hff});
			pulse(core_in_rd);
			full = 1'b0;
			flags();
			w = 16'($urandom);
			core_out_data = w;
			pulse(core_out_wr);
			empty = 1'b0;
			flags();
			for (int b = 0; b < 2; b++) begin
				if (!cfg[0] && b != cfg[3]) continue;
				i_host.acc(1'b1, 1'b1, b[0], 1'b0, 8'h00, q);
				e_o += int_en_out;
				chk("rd_byte", q, (b[0] ^ cfg[3]) ? w[15:8] : w[7:0]);
				if (!cfg[0] || b == 1) empty = 1'b1;
				flags();
			end
			// Status select with both byte-select levels; the wrong one reads zero.
			// In 8-bit mode a third pass reads data at the reserved byte-select level.
			for (int b = 0; b < 3; b++) begin
				if (b == 2 && cfg[0]) continue;
				i_host.acc(1'b1, 1'b1, (b == 2) ? ~cfg[3] : b[0], b < 2, 8'h00, q);
				e_o += int_en_out;
				chk("stat_byte", q, b == cfg[3] ? stat_exp() : 8'h00);
			end
			// Reserved reads must leave the flags alone.
			flags();
			chk("irq_in", n_i, e_i);
			chk("irq_out", n_o, e_o);
		end
		stop_test();
	end
endmodule

// ==== hw/hpp_port.sv ====
// Passive 8-bit host parallel port with 16-bit input and output buffers.
`timescale 1ns/10ps
`include "hpp_cfg.svh"
module hpp_port (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic port_chip_select_n,
	input wire logic input_data_strobe,
	input wire logic output_data_strobe,
	input wire logic byte_select,
	input wire logic status_select,
	input wire logic [7:0] host_data_bus_in,
	output logic [7:0] host_data_bus_out,
	output logic host_data_bus_oe_n,
	output logic input_full_flag,
	output logic output_empty_flag,
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	output logic [7:0] ctrl_rdata,
	output logic [7:0] status_rdata,
	input wire logic core_in_rd,
	output logic [15:0] core_in_data,
	input wire logic core_out_wr,
	input wire logic [15:0] core_out_data,
	input wire logic int_en_in,
	input wire logic int_en_out,
	output logic irq_in_strobe,
	output logic irq_out_strobe
);

	// Width of the synchronised pin bundle.
	localparam int PW = $bits(hpp_pkg::hpp_pins_t);

	// Idle level of every host pin: deselected, strobes high, selects low.
	// A synchroniser cleared to zeros would look like chip select low with both
	// strobes asserted, and the port would take a false write right after reset.
	localparam hpp_pkg::hpp_pins_t PINS_IDLE = '{
		chip_select_n: 1'b1,
		input_data_strobe: 1'b1,
		output_data_strobe: 1'b1,
		byte_select: 1'b0,
		status_select: 1'b0,
		host_data_bus: `HPP_BYTE_ZERO
	};

	// Raw pins gathered for the synchroniser.
	logic [PW-1:0] raw_pins;
	// Synchronised pins as a flat vector.
	logic [PW-1:0] sync_pins;
	// Synchronised pins as a struct.
	hpp_pkg::hpp_pins_t p;
	// Registered state.
	hpp_pkg::hpp_state_t state_ff;
	// Next state.
	hpp_pkg::hpp_state_t nxt_state;

	// Decoded host access terms, taken from synchronised pins, the control register and the flags.
	// Set when 16-bit transfers are selected.
	logic mode16;
	// Byte select polarity from the control register.
	logic sel_pol;
	// Set when the single data strobe protocol is selected.
	logic single;
	// Single data strobe seen through its programmed active level.
	logic ds_on;
	// A host write access stands this cycle.
	logic wr_on;
	// A host read access stands this cycle.
	logic rd_on;
	// The access addresses the high byte of a buffer.
	logic is_high;
	// Byte select is at the level legal for status and 8-bit accesses.
	logic sel_ok;
	// The selection is not a reserved one.
	logic acc_valid;
	// Completion of this byte sets the matching flag.
	logic acc_last;
	// A host write completes this cycle and sets the full flag.
	logic set_full;
	// A host read completes this cycle and sets the empty flag.
	logic set_empty;
	// Status byte as the host would read it now.
	logic [7:0] stat_byte;

	// Every host pin arrives from outside the clock domain.
	assign raw_pins = {port_chip_select_n, input_data_strobe, output_data_strobe,
		byte_select, status_select, host_data_bus_in};

	// Two flip-flops before any decode looks at a pin.
	hpp_sync #(
		.W(PW),
		.RST_VAL(PINS_IDLE)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.d(raw_pins),
		.q(sync_pins)
	);

	assign p = hpp_pkg::hpp_pins_t'(sync_pins);

	// Builds the status byte from the flags; the empty bit may be inverted for software only.
	function automatic logic [7:0] make_status(input logic full, input logic empty,
		input logic inv);
		logic [7:0] s;
		s = `HPP_BYTE_ZERO;
		s[`HPP_STAT_FULL_BIT] = full;
		s[`HPP_STAT_EMPTY_BIT] = empty ^ inv;
		return s;
	endfunction

	// Access decode. The strobe protocol and polarities come from the control register.
	always_comb begin
		mode16 = state_ff.host_port_control[`HPP_CTL_WIDTH_BIT];
		sel_pol = state_ff.host_port_control[`HPP_CTL_BSEL_POL_BIT];
		single = state_ff.host_port_control[`HPP_CTL_STROBE_BIT];
		// Single strobe polarity: set means active high, clear means active low.
		ds_on = state_ff.host_port_control[`HPP_CTL_DS_POL_BIT] ?
			p.input_data_strobe : ~p.input_data_strobe;
		// The output strobe pin carries the read/write line in single strobe mode.
		if (single) begin
			wr_on = ~p.chip_select_n & ds_on & ~p.output_data_strobe;
			rd_on = ~p.chip_select_n & ds_on & p.output_data_strobe;
		end else begin
			// Separate strobes are active low; a write wins if the host drives both.
			wr_on = ~p.chip_select_n & ~p.input_data_strobe;
			rd_on = ~p.chip_select_n & ~p.output_data_strobe & p.input_data_strobe;
		end
		// Byte select as seen through the polarity bit: one means the high byte.
		is_high = mode16 & (p.byte_select ^ sel_pol);
		// The level equal to the polarity bit is the only legal one for status and 8-bit.
		sel_ok = ~(p.byte_select ^ sel_pol);
		if (p.status_select) begin
			acc_valid = sel_ok;
		end else begin
			acc_valid = mode16 | sel_ok;
		end
		// Flags follow the high byte for polarity zero, the low byte for polarity one.
		if (mode16) begin
			acc_last = is_high ^ sel_pol;
		end else begin
			acc_last = 1'b1;
		end
		stat_byte = make_status(state_ff.input_full_flag, state_ff.output_empty_flag,
			state_ff.host_port_control[`HPP_CTL_STAT_EMPTY_POL_BIT]);
	end

	// Next-state logic for the whole port.
	always_comb begin
		nxt_state = state_ff;
		set_full = 1'b0;
		set_empty = 1'b0;

		// Core side control register write.
		if (ctrl_wr) begin
			nxt_state.host_port_control = ctrl_wdata;
		end

		// Host write: hold the latest byte while the strobe stands, commit on release.
		nxt_state.wr_act = wr_on;
		if (wr_on) begin
			nxt_state.wr_byte = p.host_data_bus;
			nxt_state.wr_high = is_high;
			// A write with status select is not a data access and is dropped.
			nxt_state.wr_valid = acc_valid & ~p.status_select;
			nxt_state.wr_last = acc_last;
		end else if (state_ff.wr_act && state_ff.wr_valid) begin
			// Completion of a legal host write lands in the input buffer.
			if (state_ff.wr_high) begin
				nxt_state.in_buf[15:8] = state_ff.wr_byte;
			end else begin
				nxt_state.in_buf[7:0] = state_ff.wr_byte;
			end
			set_full = state_ff.wr_last;
		end

		// Host read: drive the bus from a flip-flop while the strobe stands.
		nxt_state.rd_act = rd_on;
		if (rd_on) begin
			nxt_state.bus_oe_n = 1'b0;
			nxt_state.rd_valid = acc_valid & ~p.status_select;
			nxt_state.rd_last = acc_last;
			if (!acc_valid) begin
				// Reserved selections read as zero and set no flag; the strobe still raises an enabled interrupt.
				nxt_state.bus_out = `HPP_BYTE_ZERO;
			end else if (p.status_select) begin
				nxt_state.bus_out = stat_byte;
			end else if (is_high) begin
				nxt_state.bus_out = state_ff.out_buf[15:8];
			end else begin
				nxt_state.bus_out = state_ff.out_buf[7:0];
			end
		end else begin
			// Release the bus as soon as the strobe drops.
			nxt_state.bus_oe_n = 1'b1;
			nxt_state.bus_out = `HPP_BYTE_ZERO;
			if (state_ff.rd_act && state_ff.rd_valid) begin
				set_empty = state_ff.rd_last;
			end
		end

		// Core writes the output buffer.
		if (core_out_wr) begin
			nxt_state.out_buf = core_out_data;
		end

		// A host completion in the same cycle as a core clear wins, so no event is lost.
		nxt_state.input_full_flag = (state_ff.input_full_flag & ~core_in_rd) | set_full;
		nxt_state.output_empty_flag = (state_ff.output_empty_flag & ~core_out_wr) |
			set_empty;

		// One-cycle interrupt pulses on the leading edge of each enabled strobe.
		nxt_state.irq_in = wr_on & ~state_ff.wr_act & int_en_in;
		nxt_state.irq_out = rd_on & ~state_ff.rd_act & int_en_out;

		// Flag pins are registered from the next flag values so they track the flags.
		if (nxt_state.host_port_control[`HPP_CTL_FLAG_OR_BIT]) begin
			// The OR is always positive, whatever the pin polarity bit says.
			nxt_state.pin_full = nxt_state.input_full_flag |
				nxt_state.output_empty_flag;
		end else begin
			nxt_state.pin_full = nxt_state.input_full_flag ^
				nxt_state.host_port_control[`HPP_CTL_FLAG_POL_BIT];
		end
		nxt_state.pin_empty = nxt_state.output_empty_flag ^
			nxt_state.host_port_control[`HPP_CTL_FLAG_POL_BIT];

		// Core view of the status byte.
		nxt_state.host_port_status_byte = make_status(nxt_state.input_full_flag,
			nxt_state.output_empty_flag,
			nxt_state.host_port_control[`HPP_CTL_STAT_EMPTY_POL_BIT]);
	end

	// State register. After reset the input buffer is empty and the output buffer is empty,
	// so the empty flag starts set and the host knows there is nothing to read.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_ff <= '0;
			state_ff.host_port_control <= `HPP_CTL_RESET;
			state_ff.in_buf <= `HPP_BUF_RESET;
			state_ff.out_buf <= `HPP_BUF_RESET;
			state_ff.output_empty_flag <= 1'b1;
			state_ff.pin_empty <= 1'b1;
			state_ff.bus_oe_n <= 1'b1;
			state_ff.bus_out <= `HPP_BYTE_ZERO;
			state_ff.host_port_status_byte <= `HPP_STAT_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Every output comes straight from the state register.
	// Host bus drive and its enable, low while the port drives the bus.
	assign host_data_bus_out = state_ff.bus_out;
	assign host_data_bus_oe_n = state_ff.bus_oe_n;
	// Flag pins, already carrying their programmed polarity, except the full pin in OR mode, which is always positive.
	assign input_full_flag = state_ff.pin_full;
	assign output_empty_flag = state_ff.pin_empty;
	// Core side views of the control register, the status byte and the input buffer.
	assign ctrl_rdata = state_ff.host_port_control;
	assign status_rdata = state_ff.host_port_status_byte;
	assign core_in_data = state_ff.in_buf;
	assign irq_in_strobe = state_ff.irq_in;
	assign irq_out_strobe = state_ff.irq_out;

endmodule

// ==== hw/hpp_sync.sv ====
// Two-stage synchroniser for a bundle of host pins.
`timescale 1ns/10ps
module hpp_sync #(
	parameter int W = 13,
	// Pattern both stages load on reset; it should be the idle level of the pins.
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	// First stage, read only by the second stage.
	logic [W-1:0] meta_ff;
	// Second stage, safe for logic.
	logic [W-1:0] safe_ff;

	// Both stages load the idle pattern on reset, so no false access follows release.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_ff <= RST_VAL;
			safe_ff <= RST_VAL;
		end else begin
			meta_ff <= d;
			safe_ff <= meta_ff;
		end
	end

	// Only the second stage leaves the module.
	assign q = safe_ff;

endmodule
